// ### design/rtc_pkg.sv
// package: register map, field positions, timing and carrier types for the rtc control block
package rtc_pkg;
	// register indices on the 3-bit select lines
	localparam logic [2:0] ADDR_SEC = 3'h0;
	localparam logic [2:0] ADDR_MIN = 3'h1;
	localparam logic [2:0] ADDR_HOUR = 3'h2;
	localparam logic [2:0] ADDR_DAY = 3'h3;
	localparam logic [2:0] ADDR_MONTH = 3'h4;
	localparam logic [2:0] ADDR_FREEZE = 3'h1;
	localparam logic [2:0] ADDR_CTRL = 3'h7;
	// control word fields
	localparam int CTRL_RUN_BIT = 2;
	localparam int CTRL_ALARM_BIT = 3;
	localparam int CTRL_CLKSEL_LSB = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// status bits
	localparam int STAT_CLK_BIT = 6;
	localparam int STAT_ALARM_BIT = 7;
	// alarm hour latch reset value keeps alarm from matching during init
	localparam logic [7:0] HOUR_ALARM_RESET = 8'h30;
	// freeze window
	localparam int CLK_HZ = 20_000_000;
	localparam int FREEZE_MS = 250;
	localparam int FREEZE_CYCLES = (CLK_HZ / 1000) * FREEZE_MS;
	localparam int FREEZE_W = 23;

	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
	} alarm_set_t;

	typedef enum logic [1:0] {
		IDLE,
		WRITE,
		READ
	} access_state_t;
endpackage

// ### design/rtc_control.sv
// rtc control word, host access, freeze, interrupt and power-down logic
`timescale 1ns/1ns
module rtc_control #(
	parameter int FREEZE_CYCLES = rtc_pkg::FREEZE_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic io_mode_i,
	input wire logic chip_select_i,
	input wire logic timing_pulse_a_i,
	input wire logic write_or_pulse_b_i,
	input wire logic cpu_read_dir_i,
	input wire logic [2:0] reg_select_lines_i,
	input wire logic [7:0] host_data_lines_i,
	input wire logic power_down_n_i,
	input wire logic sec_tick_i,
	input wire logic [14:0] clk_taps_i,
	input wire logic [7:0] cnt_sec_i,
	input wire logic [7:0] cnt_min_i,
	input wire logic [7:0] cnt_hour_i,
	input wire logic [7:0] cnt_day_i,
	input wire logic [7:0] cnt_month_i,
	output logic [7:0] host_data_lines_o,
	output logic host_data_lines_oe_o,
	output logic int_n_o,
	output logic int_oe_o,
	output logic clock_out_o,
	output logic counter_tick_o,
	output logic [2:0] counter_load_sel_o,
	output logic counter_load_o,
	output logic [7:0] counter_load_data_o,
	output logic [1:0] freq_select_o,
	output rtc_pkg::alarm_set_t alarm_o,
	output logic freeze_active_o
);

	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [6:0] sync1_q;
	logic [6:0] sync2_q;
	logic [10:0] bus1_q;
	logic [10:0] bus2_q;
	logic io_mode;
	logic cs_pin;
	logic timing_pulse_a;
	logic write_or_pulse_b;
	logic rd;
	logic pd_n;
	logic tick;
	logic [2:0] sel_lines;
	logic [7:0] din;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			// memory-mode idle levels: strobes high, mode and select low
			sync1_q <= 7'h1E;
			sync2_q <= 7'h1E;
			bus1_q <= 11'h000;
			bus2_q <= 11'h000;
		end
		else
		begin
			sync1_q <= {io_mode_i, chip_select_i, timing_pulse_a_i, write_or_pulse_b_i,
				cpu_read_dir_i, power_down_n_i, sec_tick_i};
			sync2_q <= sync1_q;
			bus1_q <= {reg_select_lines_i, host_data_lines_i};
			bus2_q <= bus1_q;
		end
	end

	assign io_mode = sync2_q[6];
	assign cs_pin = sync2_q[5];
	assign timing_pulse_a = sync2_q[4];
	assign write_or_pulse_b = sync2_q[3];
	assign rd = sync2_q[2];
	assign pd_n = sync2_q[1];
	assign tick = sync2_q[0];
	assign sel_lines = bus2_q[10:8];
	assign din = bus2_q[7:0];

	// ------------------------------------------------------------
	// edge history and chip select / address latching
	// ------------------------------------------------------------
	logic tpa_prev_q;
	logic tpb_prev_q;
	logic tick_prev_q;
	logic cs_q;
	logic [2:0] io_addr_q;
	logic tpa_fall;
	logic tpb_fall;
	logic wr_rise;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			tpa_prev_q <= 1'b1;
			tpb_prev_q <= 1'b1;
			tick_prev_q <= 1'b0;
		end
		else
		begin
			tpa_prev_q <= timing_pulse_a;
			tpb_prev_q <= write_or_pulse_b;
			tick_prev_q <= tick;
		end
	end

	assign tpa_fall = tpa_prev_q && !timing_pulse_a;
	assign tpb_fall = tpb_prev_q && !write_or_pulse_b;
	assign wr_rise = !tpb_prev_q && write_or_pulse_b;

	logic powered;

	// tpa tied high keeps the latch transparent
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cs_q <= 1'b0;
			io_addr_q <= 3'h0;
		end
		else if (powered)
		begin
			if (timing_pulse_a || tpa_fall)
				cs_q <= cs_pin;
			if (timing_pulse_a)
				io_addr_q <= sel_lines;
		end
	end

	logic [2:0] addr;
	assign addr = io_mode ? io_addr_q : sel_lines;

	// ------------------------------------------------------------
	// access detection
	// ------------------------------------------------------------
	logic mem_wr_active;
	logic mem_rd_active;
	logic io_wr_active;
	logic io_rd_window_q;
	logic wr_commit;
	logic access_busy;

	assign mem_wr_active = !io_mode && cs_q && !write_or_pulse_b && rd;
	assign mem_rd_active = !io_mode && cs_q && !rd && write_or_pulse_b;
	assign io_wr_active = io_mode && cs_q && write_or_pulse_b && !rd;

	// io read window opens at pulse a fall, closes at pulse b fall
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			io_rd_window_q <= 1'b0;
		else if (!io_mode || !powered || tpb_fall)
			io_rd_window_q <= 1'b0;
		else if (tpa_fall && cs_pin && rd)
			io_rd_window_q <= 1'b1;
	end

	// memory write commits on strobe rise, io write on pulse b fall
	assign wr_commit = powered && cs_q &&
		(io_mode ? (!rd && tpb_fall) : (rd && wr_rise));
	assign access_busy = mem_wr_active || mem_rd_active || io_wr_active || io_rd_window_q;

	// ------------------------------------------------------------
	// power-down deferred to the end of a cycle
	// ------------------------------------------------------------
	logic pd_q;
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pd_q <= 1'b0;
		else if (pd_n)
			pd_q <= 1'b0;
		else if (!access_busy)
			pd_q <= 1'b1;
	end
	assign powered = !pd_q;

	// ------------------------------------------------------------
	// control word and alarm latches
	// ------------------------------------------------------------
	logic [7:0] ctrl_q;
	rtc_pkg::alarm_set_t alarm_q;
	logic [3:0] clk_sel;
	logic alarm_en;
	logic ctrl_wr;
	logic latch_wr;

	assign clk_sel = ctrl_q[rtc_pkg::CTRL_CLKSEL_LSB +: 4];
	assign alarm_en = ctrl_q[rtc_pkg::CTRL_ALARM_BIT];
	assign ctrl_wr = wr_commit && addr == rtc_pkg::ADDR_CTRL;
	assign latch_wr = wr_commit && alarm_en && addr <= rtc_pkg::ADDR_HOUR;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			ctrl_q <= rtc_pkg::CTRL_RESET;
		else if (ctrl_wr)
			ctrl_q <= din;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			alarm_q.sec <= 8'h00;
			alarm_q.min <= 8'h00;
			alarm_q.hour <= rtc_pkg::HOUR_ALARM_RESET;
		end
		else if (latch_wr)
		begin
			if (addr == rtc_pkg::ADDR_SEC)
				alarm_q.sec <= din;
			else if (addr == rtc_pkg::ADDR_MIN)
				alarm_q.min <= din;
			else
				alarm_q.hour <= din;
		end
	end

	// counter writes go out when bit 3 is low
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			counter_load_o <= 1'b0;
			counter_load_sel_o <= 3'h0;
			counter_load_data_o <= 8'h00;
		end
		else
		begin
			counter_load_o <= wr_commit && !alarm_en && addr <= rtc_pkg::ADDR_MONTH;
			counter_load_sel_o <= addr;
			counter_load_data_o <= din;
		end
	end

	// ------------------------------------------------------------
	// freeze: arm on address one write, hold one tick
	// ------------------------------------------------------------
	logic freeze_q;
	logic pend_q;
	logic [rtc_pkg::FREEZE_W-1:0] frz_cnt_q;
	logic tick_rise;
	logic hold;

	assign tick_rise = tick && !tick_prev_q;
	assign hold = freeze_q || access_busy;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			freeze_q <= 1'b0;
			frz_cnt_q <= '0;
		end
		else if (wr_commit && addr == rtc_pkg::ADDR_FREEZE)
		begin
			freeze_q <= 1'b1;
			frz_cnt_q <= rtc_pkg::FREEZE_W'(FREEZE_CYCLES - 1);
		end
		else if (freeze_q && !access_busy)
		begin
			// window expiry is the only release; host accesses pause the countdown
			if (frz_cnt_q == '0)
				freeze_q <= 1'b0;
			else
				frz_cnt_q <= frz_cnt_q - 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			pend_q <= 1'b0;
			counter_tick_o <= 1'b0;
		end
		else
		begin
			counter_tick_o <= 1'b0;
			if (hold)
			begin
				if (tick_rise)
					pend_q <= 1'b1;
			end
			else if (pend_q || tick_rise)
			begin
				pend_q <= 1'b0;
				counter_tick_o <= ctrl_q[rtc_pkg::CTRL_RUN_BIT];
			end
		end
	end

	// ------------------------------------------------------------
	// clock out and interrupt status
	// ------------------------------------------------------------
	logic wave;
	logic wave_prev_q;
	logic [1:0] status_q;
	logic alarm_match;
	logic clk_fall;

	assign wave = clk_sel == 4'h0 ? 1'b1 : clk_taps_i[clk_sel - 4'h1];
	assign clk_fall = clk_sel != 4'h0 && wave_prev_q && !wave;
	assign alarm_match = alarm_en && cnt_sec_i == alarm_q.sec &&
		cnt_min_i == alarm_q.min && cnt_hour_i == alarm_q.hour;

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			wave_prev_q <= 1'b1;
		else
			wave_prev_q <= wave;
	end

	// set wins over the control-write clear
	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			status_q <= 2'b00;
		else
		begin
			status_q[0] <= clk_fall || (status_q[0] && !ctrl_wr);
			status_q[1] <= alarm_match || (status_q[1] && !ctrl_wr);
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			clock_out_o <= 1'b1;
		else
			clock_out_o <= powered ? wave : 1'b0;
	end

	logic irq;
	assign irq = |status_q;
	// in power-down only an active interrupt drives; otherwise released
	assign int_n_o = !irq;
	assign int_oe_o = powered || irq;

	// ------------------------------------------------------------
	// read data
	// ------------------------------------------------------------
	logic [7:0] rdata;
	always_comb
	begin
		rdata = 8'h00;
		if (addr == rtc_pkg::ADDR_CTRL)
		begin
			rdata[rtc_pkg::STAT_CLK_BIT] = status_q[0];
			rdata[rtc_pkg::STAT_ALARM_BIT] = status_q[1];
		end
		else if (addr == rtc_pkg::ADDR_SEC)
			rdata = cnt_sec_i;
		else if (addr == rtc_pkg::ADDR_MIN)
			rdata = cnt_min_i;
		else if (addr == rtc_pkg::ADDR_HOUR)
			rdata = cnt_hour_i;
		else if (addr == rtc_pkg::ADDR_DAY)
			rdata = cnt_day_i;
		else if (addr == rtc_pkg::ADDR_MONTH)
			rdata = cnt_month_i;
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			host_data_lines_o <= 8'h00;
			host_data_lines_oe_o <= 1'b0;
		end
		else
		begin
			host_data_lines_o <= rdata;
			host_data_lines_oe_o <= powered && (mem_rd_active || io_rd_window_q);
		end
	end

	assign freq_select_o = ctrl_q[1:0];
	assign alarm_o = alarm_q;
	assign freeze_active_o = freeze_q;

endmodule // rtc_control

// ### testbench/rtc_checker_assertions.sv
// property checks on the rtc control block pins
`timescale 1ns/1ns
module rtc_checker (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic io_mode_i,
	input wire logic chip_select_i,
	input wire logic write_or_pulse_b_i,
	input wire logic cpu_read_dir_i,
	input wire logic [2:0] reg_select_lines_i,
	input wire logic power_down_n_i,
	input wire logic host_data_lines_oe_o,
	input wire logic int_n_o,
	input wire logic int_oe_o,
	input wire logic clock_out_o,
	input wire logic counter_tick_o,
	input wire logic freeze_active_o
);
	logic mem_ok;
	assign mem_ok = chip_select_i && !io_mode_i && power_down_n_i;
	default clocking @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ------------------------------------------------
	// strobes seen raw; two sync stages explain the ranges
	// ------------------------------------------------
	a_tick_single:
		assert property (counter_tick_o |=> !counter_tick_o)
		else $error("tick wider than one cycle");
	a_freeze_hold:
		assert property ($past(freeze_active_o) && freeze_active_o |-> !counter_tick_o)
		else $error("tick while frozen");
	a_freeze_arm:
		assert property ($rose(write_or_pulse_b_i) && mem_ok && cpu_read_dir_i
			&& reg_select_lines_i == 3'h1 |-> ##[1:6] freeze_active_o)
		else $error("freeze not armed");
	a_read_drive:
		assert property ($fell(cpu_read_dir_i) && write_or_pulse_b_i && mem_ok
			|-> ##[2:5] host_data_lines_oe_o)
		else $error("read not driven");
	a_read_release:
		assert property ($rose(cpu_read_dir_i) && !io_mode_i |-> ##[1:4] !host_data_lines_oe_o)
		else $error("bus not released");
	a_pd_clkout:
		assert property (!power_down_n_i [*8] |-> !clock_out_o)
		else $error("clock out high in power down");
	a_int_release:
		assert property ($rose(write_or_pulse_b_i) && mem_ok && cpu_read_dir_i
			&& reg_select_lines_i == 3'h7 |-> ##[2:6] int_n_o)
		else $error("interrupt kept after control write");
	a_int_driven:
		assert property (power_down_n_i [*8] |-> int_oe_o)
		else $error("interrupt floated while running");
	a_io_read_end:
		assert property ($fell(write_or_pulse_b_i) && io_mode_i |-> ##[2:5] !host_data_lines_oe_o)
		else $error("io read drive kept after pulse b");
	c_io_read: cover property (io_mode_i && host_data_lines_oe_o);
	c_tick: cover property (counter_tick_o);
	c_frozen: cover property (freeze_active_o);
	c_irq: cover property (!int_n_o);
endmodule // rtc_checker

bind rtc_control rtc_checker i_rtc_checker (
	.sys_clk_i, .rst_n_i, .io_mode_i, .chip_select_i, .write_or_pulse_b_i, .cpu_read_dir_i,
	.reg_select_lines_i, .power_down_n_i, .host_data_lines_oe_o, .int_n_o, .int_oe_o,
	.clock_out_o, .counter_tick_o, .freeze_active_o
);

// ### testbench/host.sv
// host processor model: memory-mapped and io-mode bus cycles toward the rtc block
`timescale 1ns/1ns
module host (
	input wire logic clk_i,
	input wire logic oe_i,
	input wire logic [7:0] rdata_i,
	output logic cs_o,
	output logic wr_n_o,
	output logic rd_n_o,
	output logic [2:0] sel_o,
	output logic [7:0] data_o,
	output logic io_o,
	output logic tpa_o
);
	initial
	begin
		cs_o = 1'b0;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		sel_o = 3'h0;
		data_o = 8'hA5;
		io_o = 1'b0;
		tpa_o = 1'b1;
	end
	// ------------------------------------------------
	// strobes at least 3 clocks wide: the block syncs its inputs
	// ------------------------------------------------
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_i);
		cs_o = 1'b1;
		sel_o = a;
		data_o = d;
		wr_n_o = 1'b0;
		repeat (3) @(negedge clk_i);
		wr_n_o = 1'b1;
		repeat (3) @(negedge clk_i);
		cs_o = 1'b0;
		data_o = ~d; // released bus never shows the old byte
		repeat (2) @(negedge clk_i);
	endtask
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		int n;
		@(negedge clk_i);
		cs_o = 1'b1;
		sel_o = a;
		rd_n_o = 1'b0;
		n = 0;
		while (oe_i !== 1'b1 && n < 8)
		begin
			@(negedge clk_i);
			n++;
		end
		d = (oe_i === 1'b1) ? rdata_i : 8'hXX;
		rd_n_o = 1'b1;
		repeat (4) @(negedge clk_i);
		cs_o = 1'b0;
	endtask
	// ------------------------------------------------
	// io mode: pulses idle low, select and address dropped after pulse a
	// ------------------------------------------------
	task automatic io_enter;
		@(negedge clk_i);
		io_o = 1'b1;
		tpa_o = 1'b0;
		wr_n_o = 1'b0;
		repeat (4) @(negedge clk_i);
	endtask
	task automatic io_wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_i);
		cs_o = 1'b1;
		sel_o = a;
		data_o = d;
		rd_n_o = 1'b0;
		tpa_o = 1'b1;
		repeat (3) @(negedge clk_i);
		tpa_o = 1'b0;
		@(negedge clk_i);
		cs_o = 1'b0;
		sel_o = ~a;
		wr_n_o = 1'b1;
		repeat (3) @(negedge clk_i);
		wr_n_o = 1'b0;
		repeat (3) @(negedge clk_i);
		rd_n_o = 1'b1;
		data_o = ~d;
		repeat (2) @(negedge clk_i);
	endtask
	task automatic io_rd(input logic [2:0] a, output logic [7:0] d);
		int n;
		@(negedge clk_i);
		cs_o = 1'b1;
		sel_o = a;
		rd_n_o = 1'b1;
		tpa_o = 1'b1;
		repeat (3) @(negedge clk_i);
		tpa_o = 1'b0;
		@(negedge clk_i);
		cs_o = 1'b0;
		sel_o = ~a;
		n = 0;
		while (oe_i !== 1'b1 && n < 8)
		begin
			@(negedge clk_i);
			n++;
		end
		d = (oe_i === 1'b1) ? rdata_i : 8'hXX;
		wr_n_o = 1'b1;
		repeat (3) @(negedge clk_i);
		wr_n_o = 1'b0;
		repeat (4) @(negedge clk_i);
	endtask
endmodule // host

// ### testbench/testbench.sv
// self-checking testbench for the rtc control block
`timescale 1ns/1ns
module testbench;
	localparam int FRZ = 50;
	logic sys_clk_i, rst_n_i, cs, wr_n, rd_n, pd_n, tick, oe, int_n, int_oe, clk_out, ctk, ld, frz;
	logic io, timing_pulse_a;
	logic [1:0] fsel;
	logic [2:0] sel, lsel, last_s;
	logic [7:0] wd, rdat, ldat, last_d, cnt_v, got, ticks, loads, l0;
	logic [19:0] tcnt;
	rtc_pkg::alarm_set_t alarm;
	int err_count, check_count;
	rtc_control #(.FREEZE_CYCLES(FRZ)) i_rtc_control (
		.sys_clk_i, .rst_n_i, .io_mode_i(io), .chip_select_i(cs), .timing_pulse_a_i(timing_pulse_a),
		.write_or_pulse_b_i(wr_n), .cpu_read_dir_i(rd_n), .reg_select_lines_i(sel),
		.host_data_lines_i(wd), .power_down_n_i(pd_n), .sec_tick_i(tick),
		.clk_taps_i(tcnt[19:5]), .cnt_sec_i(cnt_v), .cnt_min_i(cnt_v), .cnt_hour_i(cnt_v),
		.cnt_day_i(cnt_v), .cnt_month_i(cnt_v), .host_data_lines_o(rdat),
		.host_data_lines_oe_o(oe), .int_n_o(int_n), .int_oe_o(int_oe), .clock_out_o(clk_out),
		.counter_tick_o(ctk), .counter_load_sel_o(lsel), .counter_load_o(ld),
		.counter_load_data_o(ldat), .freq_select_o(fsel), .alarm_o(alarm), .freeze_active_o(frz)
	);
	host i_host (
		.clk_i(sys_clk_i), .oe_i(oe), .rdata_i(rdat), .cs_o(cs), .wr_n_o(wr_n), .rd_n_o(rd_n),
		.sel_o(sel), .data_o(wd), .io_o(io), .tpa_o(timing_pulse_a)
	);
	initial
	begin
		sys_clk_i = 1'b0;
		forever #25 sys_clk_i = ~sys_clk_i;
	end
	always @(negedge sys_clk_i)
		tcnt <= tcnt + 20'h00001;
	// pulses are counted mid-cycle, where they have settled
	always @(negedge sys_clk_i)
	begin
		if (ctk === 1'b1)
			ticks <= ticks + 8'h01;
		if (ld === 1'b1)
			loads <= loads + 8'h01;
		if (ld === 1'b1)
			last_d <= ldat;
		if (ld === 1'b1)
			last_s <= lsel;
	end
	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_count++;
			$display("BAD %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic sec_pulse;
		@(negedge sys_clk_i);
		tick = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		tick = 1'b0;
		repeat (6) @(negedge sys_clk_i);
	endtask
	initial
	begin
		repeat (5000) @(posedge sys_clk_i);
		err_count++;
		conclude();
	end
	initial
	begin
		rst_n_i = 1'b0;
		pd_n = 1'b1;
		tick = 1'b0;
		cnt_v = 8'h07;
		tcnt = 20'h00000;
		ticks = 8'h00;
		loads = 8'h00;
		repeat (5) @(negedge sys_clk_i);
		rst_n_i = 1'b1;
		repeat (3) @(negedge sys_clk_i);
		check(8'(clk_out), 8'h01);
		i_host.wr(3'h7, 8'h00);
		sec_pulse();
		check(ticks, 8'h00);
		i_host.wr(3'h7, 8'h0C);
		sec_pulse();
		check(ticks, 8'h01);
		i_host.wr(3'h0, 8'h45);
		check(alarm.sec, 8'h45);
		check(loads, 8'h00);
		i_host.wr(3'h7, 8'h04);
		i_host.wr(3'h0, 8'h12);
		check(loads, 8'h01);
		check(last_d, 8'h12);
		cnt_v = 8'h59;
		i_host.rd(3'h0, got);
		check(got, 8'h59);
		i_host.wr(3'h7, 8'h14);
		repeat (80) @(negedge sys_clk_i);
		check(8'(int_n), 8'h00);
		i_host.rd(3'h7, got);
		check(got, 8'h40);
		i_host.wr(3'h7, 8'h04);
		check(8'(int_n), 8'h01);
		i_host.rd(3'h7, got);
		check(got, 8'h00);
		i_host.wr(3'h1, 8'h00);
		check(8'(frz), 8'h01);
		sec_pulse();
		sec_pulse();
		check(ticks, 8'h01);
		repeat (FRZ + 20) @(negedge sys_clk_i);
		check(ticks, 8'h02);
		l0 = loads;
		pd_n = 1'b0;
		repeat (8) @(negedge sys_clk_i);
		check(8'(clk_out), 8'h00);
		check(8'(int_oe), 8'h00);
		i_host.wr(3'h0, 8'h33);
		check(loads, l0);
		pd_n = 1'b1;
		repeat (8) @(negedge sys_clk_i);
		check(8'(clk_out), 8'h01);
		i_host.io_enter();
		i_host.io_wr(3'h7, 8'h05);
		check(8'(fsel), 8'h01);
		i_host.io_wr(3'h2, 8'h08);
		check(8'(last_s), 8'h02);
		check(last_d, 8'h08);
		cnt_v = 8'h31;
		i_host.io_rd(3'h0, got);
		check(got, 8'h31);
		check(8'(oe), 8'h00);
		conclude();
	end
endmodule // testbench
